// file: inc/cwt_pkg.sv
// Purpose: Constants and types for the serial window timeout control block
// Assumes: 125 MHz core clock, serial target reached over its two bus pins
// Notes:   One place for offsets, field positions, resets and timing
// What this block does
// - The ready-line timeout equals the timeout register times 0.32 ms.
// - The timeout register resets to 0x20, a default of 10.24 ms.
// - With stop-disable clear, a STOP closes the communication window.
// - With stop-disable set, only a START-free timeout closes the window.
// - Reseed bits 2 to 0 enable auto reseed per channel; reset is 0x07.
// - The reseed enables gate only the two halt-timeout reseeds, not others.
// - No spike filter is applied to the serial clock and data lines.
package cwt_pkg;

    // Register offsets
    localparam logic [7:0] REG_READY_TIMEOUT_PERIOD = 8'hd9;
    localparam logic [7:0] REG_BUS_WINDOW_SETTINGS  = 8'hda;
    localparam logic [7:0] REG_AUTO_RESEED_ENABLES  = 8'hdb;

    // Reset values
    localparam logic [7:0] RST_READY_TIMEOUT_PERIOD = 8'h20;
    localparam logic [7:0] RST_BUS_WINDOW_SETTINGS  = 8'h01;
    localparam logic [7:0] RST_AUTO_RESEED_ENABLES  = 8'h07;

    // Field positions
    localparam int BIT_STOP_DISABLE = 7;
    localparam int BIT_SET_ONE      = 0;
    localparam int BIT_SENSE_CHANNEL_TWO  = 2;
    localparam int BIT_SENSE_CHANNEL_ONE  = 1;
    localparam int BIT_SENSE_CHANNEL_ZERO = 0;
    localparam int RESEED_CHANNELS  = 3;

    // Timing
    localparam int CLK_PERIOD_NS      = 8;
    localparam int TIMEOUT_STEP_NS    = 320000;
    localparam int TIMEOUT_STEP_CYCLES = TIMEOUT_STEP_NS / CLK_PERIOD_NS;

    // Default target address; arbitrary value
    localparam logic [6:0] DEF_TARGET_ADDR = 7'h44;

    // Serial target sequencer states
    typedef enum logic [2:0] {
        CWT_IDLE,
        CWT_RX,
        CWT_ACK,
        CWT_TX,
        CWT_MACK
    } cwt_state_t;

    // Role of the byte being received
    typedef enum logic [1:0] {
        CWT_BYTE_ADDR,
        CWT_BYTE_PTR,
        CWT_BYTE_DATA
    } cwt_byte_t;

endpackage : cwt_pkg

// file: inc/cwt_if.sv
// Purpose: Bus events passed from the pin monitor to the target core
// Assumes: All signals are on the core clock
// Notes:   Events are single-cycle pulses; sda is the synchronised level
`timescale 1ns/1ps
interface cwt_if;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;

    modport mon  (output start, stop, scl_rise, scl_fall, sda);
    modport core (input  start, stop, scl_rise, scl_fall, sda);
endinterface : cwt_if

// file: rtl/cwt_bus_mon.sv
// Purpose: Synchronise the serial pins and find edges, START and STOP
// Assumes: Serial clock far slower than the core clock
// Notes:   Two sync flops per pin, then edge logic on stage two and its delayed copy
`timescale 1ns/1ps
module cwt_bus_mon
    import cwt_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    cwt_if.mon        ev
);
    logic scl_ff1;
    logic scl_ff2;
    logic scl_prev;
    logic sda_ff1;
    logic sda_ff2;
    logic sda_prev;

    // Plain two-flop sync; no spike suppression, every edge counts
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_ff1  <= 1'b1;
            scl_ff2  <= 1'b1;
            scl_prev <= 1'b1;
            sda_ff1  <= 1'b1;
            sda_ff2  <= 1'b1;
            sda_prev <= 1'b1;
        end else if (ce) begin
            scl_ff1  <= scl_pin;
            scl_ff2  <= scl_ff1;
            scl_prev <= scl_ff2;
            sda_ff1  <= sda_pin;
            sda_ff2  <= sda_ff1;
            sda_prev <= sda_ff2;
        end
    end

    // Conditions from the second stage and its delayed copy
    assign ev.scl_rise = ce & scl_ff2 & ~scl_prev;
    assign ev.scl_fall = ce & ~scl_ff2 & scl_prev;
    assign ev.start    = ce & scl_ff2 & scl_prev & sda_prev & ~sda_ff2;
    assign ev.stop     = ce & scl_ff2 & scl_prev & ~sda_prev & sda_ff2;
    assign ev.sda      = sda_ff2;

endmodule : cwt_bus_mon

// file: rtl/cwt_top.sv
// Purpose: Serial target with window timeout and reseed gating registers
// Assumes: Core clock 125 MHz; bus pins asynchronous to it
// Notes:   Pointer byte then data bytes; pointer auto-increments
`timescale 1ns/1ps
module cwt_top
    import cwt_pkg::*;
#(
    parameter int         TICK_CYCLES = TIMEOUT_STEP_CYCLES,
    parameter int         NUM_CH      = RESEED_CHANNELS,
    parameter logic [6:0] TARGET_ADDR = DEF_TARGET_ADDR
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    output logic                   window_open,
    output logic                   stop_disable,
    input  wire logic [NUM_CH-1:0] halt_discrete_req,
    input  wire logic [NUM_CH-1:0] halt_quick_req,
    input  wire logic [NUM_CH-1:0] other_reseed_req,
    output logic      [NUM_CH-1:0] reseed_cmd
);
    // Refuse settings the logic cannot serve
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end
    if (NUM_CH < 1 || NUM_CH > RESEED_CHANNELS) begin : g_bad_ch
        $error("NUM_CH must be between one and three");
    end

    cwt_if ev ();

    cwt_bus_mon u_mon (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .scl_pin (scl_i),
        .sda_pin (sda_i),
        .ev      (ev)
    );

    logic [7:0]  ready_timeout_period;
    logic        set_one;
    logic [2:0]  auto_reseed_enables;
    cwt_state_t  state;
    cwt_byte_t   kind;
    logic [7:0]  ptr;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic [3:0]  bit_cnt;
    logic        rw;
    logic        nack;
    logic        tmr_run;
    logic [31:0] tick_cnt;
    logic [7:0]  unit_cnt;
    logic        byte_done;
    logic        wr_en;
    logic [7:0]  rd_byte;

    // Register read decode; unmapped and reserved bits read zero
    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [7:0] tp,
                                            input logic       sd,
                                            input logic       s1,
                                            input logic [2:0] re);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            REG_READY_TIMEOUT_PERIOD: d = tp;
            REG_BUS_WINDOW_SETTINGS: begin
                d[BIT_STOP_DISABLE] = sd;
                d[BIT_SET_ONE]      = s1;
            end
            REG_AUTO_RESEED_ENABLES: d[2:0] = re;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    assign byte_done = ev.scl_fall && bit_cnt == 4'h8 && state == CWT_RX;
    assign wr_en     = byte_done && kind == CWT_BYTE_DATA;
    assign rd_byte   = reg_read(ptr, ready_timeout_period, stop_disable,
                                set_one, auto_reseed_enables);

    // Register file writes from data bytes
    always_ff @(posedge clk) begin
        if (rst) begin
            ready_timeout_period <= RST_READY_TIMEOUT_PERIOD;
            stop_disable <= RST_BUS_WINDOW_SETTINGS[BIT_STOP_DISABLE];
            set_one      <= RST_BUS_WINDOW_SETTINGS[BIT_SET_ONE];
            auto_reseed_enables <= RST_AUTO_RESEED_ENABLES[2:0];
        end else if (ce && wr_en) begin
            case (ptr)
                REG_READY_TIMEOUT_PERIOD: ready_timeout_period <= rx_sh;
                REG_BUS_WINDOW_SETTINGS: begin
                    // Bits 6..1 are not stored; host keeps them clear
                    stop_disable <= rx_sh[BIT_STOP_DISABLE];
                    set_one      <= rx_sh[BIT_SET_ONE];
                end
                REG_AUTO_RESEED_ENABLES:
                    auto_reseed_enables <= rx_sh[2:0];
                default: ;
            endcase
        end
    end

    // Serial target sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state   <= CWT_IDLE;
            kind    <= CWT_BYTE_ADDR;
            ptr     <= 8'h00;
            rx_sh   <= 8'h00;
            tx_sh   <= 8'h00;
            bit_cnt <= 4'h0;
            rw      <= 1'b0;
            nack    <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (ce) begin
            if (ev.start) begin
                // Repeated START restarts the address phase
                state   <= CWT_RX;
                kind    <= CWT_BYTE_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (ev.stop) begin
                state  <= CWT_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    CWT_RX: begin
                        if (ev.scl_rise && bit_cnt != 4'h8) begin
                            rx_sh   <= {rx_sh[6:0], ev.sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_done) begin
                            bit_cnt <= 4'h0;
                            case (kind)
                                CWT_BYTE_ADDR: begin
                                    if (rx_sh[7:1] == TARGET_ADDR) begin
                                        rw     <= rx_sh[0];
                                        sda_oe <= 1'b1;
                                        state  <= CWT_ACK;
                                    end else begin
                                        state <= CWT_IDLE;
                                    end
                                end
                                CWT_BYTE_PTR: begin
                                    ptr    <= rx_sh;
                                    sda_oe <= 1'b1;
                                    state  <= CWT_ACK;
                                end
                                default: begin
                                    ptr    <= ptr + 8'h01;
                                    sda_oe <= 1'b1;
                                    state  <= CWT_ACK;
                                end
                            endcase
                        end
                    end
                    CWT_ACK: begin
                        if (ev.scl_fall) begin
                            if (rw) begin
                                tx_sh   <= rd_byte;
                                sda_oe  <= ~rd_byte[7];
                                bit_cnt <= 4'h1;
                                state   <= CWT_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                kind   <= (kind == CWT_BYTE_ADDR) ?
                                          CWT_BYTE_PTR : CWT_BYTE_DATA;
                                state  <= CWT_RX;
                            end
                        end
                    end
                    CWT_TX: begin
                        if (ev.scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                sda_oe <= 1'b0;
                                ptr    <= ptr + 8'h01;
                                state  <= CWT_MACK;
                            end else begin
                                tx_sh   <= {tx_sh[6:0], 1'b0};
                                sda_oe  <= ~tx_sh[6];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    CWT_MACK: begin
                        if (ev.scl_rise) begin
                            nack <= ev.sda;
                        end
                        if (ev.scl_fall) begin
                            if (nack) begin
                                state <= CWT_IDLE;
                            end else begin
                                tx_sh   <= rd_byte;
                                sda_oe  <= ~rd_byte[7];
                                bit_cnt <= 4'h1;
                                state   <= CWT_TX;
                            end
                        end
                    end
                    default: state <= CWT_IDLE;
                endcase
            end
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_o <= 1'b0;
        end else if (ce) begin
            sda_o <= 1'b0;
        end
    end

    // Communication window open and close
    always_ff @(posedge clk) begin
        if (rst) begin
            window_open <= 1'b0;
        end else if (ce) begin
            if (byte_done && kind == CWT_BYTE_ADDR &&
                rx_sh[7:1] == TARGET_ADDR) begin
                window_open <= 1'b1;
            end else if (ev.stop && !stop_disable) begin
                window_open <= 1'b0;
            end else if (tmr_run && !ev.start &&
                         unit_cnt >= ready_timeout_period) begin
                window_open <= 1'b0;
            end
        end
    end

    // Timeout in 0.32 ms units; armed by STOP, cleared by START
    always_ff @(posedge clk) begin
        if (rst) begin
            tmr_run  <= 1'b0;
            tick_cnt <= 32'h0;
            unit_cnt <= 8'h00;
        end else if (ce) begin
            if (ev.start || !window_open || !stop_disable) begin
                tmr_run  <= 1'b0;
                tick_cnt <= 32'h0;
                unit_cnt <= 8'h00;
            end else if (ev.stop) begin
                tmr_run  <= 1'b1;
                tick_cnt <= 32'h0;
                unit_cnt <= 8'h00;
            end else if (tmr_run) begin
                // Whole-unit steps; saturate so 255 units still expire
                if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
                    tick_cnt <= 32'h0;
                    if (unit_cnt != 8'hff) begin
                        unit_cnt <= unit_cnt + 8'h01;
                    end
                end else begin
                    tick_cnt <= tick_cnt + 32'h1;
                end
            end
        end
    end

    // Enables gate only halt-timeout reseeds; other requests pass
    always_ff @(posedge clk) begin
        if (rst) begin
            reseed_cmd <= '0;
        end else if (ce) begin
            reseed_cmd <= ((halt_discrete_req | halt_quick_req) &
                           auto_reseed_enables[NUM_CH-1:0]) |
                          other_reseed_req;
        end
    end

endmodule : cwt_top

// file: verification/cwt_top_sva.sv
// Purpose: Port-level checks for the serial window timeout block
// Assumes: One core clock domain, synchronous active-high reset
// Notes:   Pin events reach the core through a few cycles of sync lag
`timescale 1ns/1ps
module cwt_top_sva
    import cwt_pkg::*;
#(
    parameter int NUM_CH = RESEED_CHANNELS
)
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              ce,
    input wire logic              scl_i,
    input wire logic              sda_i,
    input wire logic              sda_o,
    input wire logic              sda_oe,
    input wire logic              window_open,
    input wire logic              stop_disable,
    input wire logic [NUM_CH-1:0] halt_discrete_req,
    input wire logic [NUM_CH-1:0] halt_quick_req,
    input wire logic [NUM_CH-1:0] other_reseed_req,
    input wire logic [NUM_CH-1:0] reseed_cmd
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // STOP as the pins show it, data rising while the clock is high
    sequence pin_stop;
        scl_i && $rose(sda_i);
    endsequence
    // Window held long enough to outlast the STOP
    sequence win_held;
        window_open [*8];
    endsequence

    chk_reset_quiet: assert property ($fell(rst) |->
        !window_open && !sda_oe && !stop_disable && reseed_cmd == '0)
        else $error("outputs not quiet after reset");
    chk_stop_close: assert property (
        (window_open && !stop_disable) ##0 pin_stop |-> ##[1:8] !window_open)
        else $error("window not closed by stop");
    chk_stop_hold: assert property (
        (window_open && stop_disable) ##0 pin_stop |=> win_held)
        else $error("window closed by ignored stop");
    chk_close_idle: assert property ($fell(window_open) |->
        scl_i && sda_i)
        else $error("window closed with bus busy");
    chk_open_ack: assert property (
        $rose(sda_oe) && !$past(window_open) |-> ##[0:4] window_open)
        else $error("window not opened at address ack");
    chk_ack_width: assert property ($rose(sda_oe) |=> sda_oe [*4])
        else $error("data drive shorter than clock phase");
    chk_drive_low: assert property (sda_o == 1'b0)
        else $error("open drain data driven high");
    chk_reseed_other: assert property (ce && other_reseed_req != '0 |=>
        (reseed_cmd & $past(other_reseed_req)) == $past(other_reseed_req))
        else $error("other reseed was gated");
    chk_reseed_idle: assert property (ce && (halt_discrete_req |
        halt_quick_req | other_reseed_req) == '0 |=> reseed_cmd == '0)
        else $error("reseed without request");
endmodule : cwt_top_sva

bind cwt_top cwt_top_sva #(.NUM_CH(NUM_CH)) cwt_top_sva_i (
    .clk(clk), .rst(rst), .ce(ce), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .window_open(window_open),
    .stop_disable(stop_disable), .halt_discrete_req(halt_discrete_req),
    .halt_quick_req(halt_quick_req), .other_reseed_req(other_reseed_req),
    .reseed_cmd(reseed_cmd));

// file: verification/cwt_host_model.sv
// Purpose: Serial bus controller driving the target's two pins
// Assumes: Pull-up on data; clock stands still outside frames
// Notes:   Bit period 8 core cycles (64 ns), low six, high two
`timescale 1ns/1ps
module cwt_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // Idle bus: both lines released
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk

    // Long first wait lets the target drop its ack before clock rises
    task automatic start_cond();
        sda_drv = 1'b1;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(2);
        sda_drv = 1'b0;
        wait_clk(2);
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        sda_drv = 1'b0;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(2);
        sda_drv = 1'b1;
        wait_clk(2);
    endtask : stop_cond

    // Nine bits MSB first; data moves only while the clock is low
    task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            wait_clk(1);
            sda_drv = tx[i];
            wait_clk(5);
            scl = 1'b1;
            wait_clk(2);
            rx[i] = sda_line;
            scl = 1'b0;
        end
    endtask : xfer9
endmodule : cwt_host_model

// file: verification/testbench.sv
// Purpose: Register and window tests for the serial timeout block
// Assumes: Timeout unit shortened to 8 core cycles
// Notes:   Data wire resolved here from both parties' drives
`timescale 1ns/1ps
module testbench
    import cwt_pkg::*;
;
    localparam int         TICK = 8;
    localparam logic [6:0] ADDR = DEF_TARGET_ADDR;
    logic       clk, rst, ce, scl, sda_m, sda_o, sda_oe;
    logic       window_open, stop_disable;
    logic [2:0] disc, quick, other, reseed_cmd;
    wire        sda_line = sda_m & ~(sda_oe & ~sda_o);
    int         err_count = 0;
    int         cmp_count = 0;
    int         cycles    = 0;

    cwt_top #(.TICK_CYCLES(TICK)) cwt_top_i (.clk(clk), .rst(rst), .ce(ce),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .window_open(window_open), .stop_disable(stop_disable),
        .halt_discrete_req(disc), .halt_quick_req(quick),
        .other_reseed_req(other), .reseed_cmd(reseed_cmd));
    cwt_host_model cwt_host_model_i (.clk(clk), .sda_line(sda_line),
        .scl(scl), .sda_drv(sda_m));

    // Core clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Window must still be open at the end of every frame
    task automatic end_frame();
        check({7'h00, window_open}, 8'h01);
        cwt_host_model_i.stop_cond();
    endtask : end_frame

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] rx;
        cwt_host_model_i.start_cond();
        cwt_host_model_i.xfer9({ADDR, 1'b0, 1'b1}, rx);
        check({7'h00, rx[0]}, 8'h00);
        cwt_host_model_i.xfer9({a, 1'b1}, rx);
        cwt_host_model_i.xfer9({d, 1'b1}, rx);
        check({7'h00, rx[0]}, 8'h00);
        end_frame();
    endtask : reg_write

    // Pointer write, repeated START, one byte read then NACK
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        logic [8:0] rx;
        cwt_host_model_i.start_cond();
        cwt_host_model_i.xfer9({ADDR, 1'b0, 1'b1}, rx);
        cwt_host_model_i.xfer9({a, 1'b1}, rx);
        cwt_host_model_i.start_cond();
        cwt_host_model_i.xfer9({ADDR, 1'b1, 1'b1}, rx);
        cwt_host_model_i.xfer9(9'h1ff, rx);
        check(rx[8:1], exp);
        end_frame();
    endtask : reg_read

    // Timeout of 3 units: open at 22 cycles after STOP, shut by 36
    task automatic expect_close();
        repeat (20) @(negedge clk);
        check({7'h00, window_open}, 8'h01);
        repeat (14) @(negedge clk);
        check({7'h00, window_open}, 8'h00);
    endtask : expect_close

    task automatic pulse(input logic [2:0] d, input logic [2:0] q,
                         input logic [2:0] o, input logic [2:0] exp);
        disc  = d;
        quick = q;
        other = o;
        @(negedge clk);
        check({5'h00, reseed_cmd}, {5'h00, exp});
        disc  = 3'h0;
        quick = 3'h0;
        other = 3'h0;
        @(negedge clk);
    endtask : pulse

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Main sequence; ce dropped once to check that it freezes state
    initial begin
        rst   = 1'b1;
        ce    = 1'b1;
        disc  = 3'h0;
        quick = 3'h0;
        other = 3'h0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        reg_read(REG_READY_TIMEOUT_PERIOD, RST_READY_TIMEOUT_PERIOD);
        reg_read(REG_BUS_WINDOW_SETTINGS, RST_BUS_WINDOW_SETTINGS);
        reg_read(REG_AUTO_RESEED_ENABLES, RST_AUTO_RESEED_ENABLES);
        reg_read(8'he0, 8'h00);
        $display("test reset values done");
        reg_write(REG_READY_TIMEOUT_PERIOD, 8'h03);
        repeat (10) @(negedge clk);
        check({7'h00, window_open}, 8'h00);
        reg_read(REG_READY_TIMEOUT_PERIOD, 8'h03);
        $display("test stop close done");
        reg_write(REG_BUS_WINDOW_SETTINGS, 8'h81);
        check({7'h00, stop_disable}, 8'h01);
        reg_read(REG_BUS_WINDOW_SETTINGS, 8'h81);
        expect_close();
        reg_write(REG_AUTO_RESEED_ENABLES, 8'h05);
        repeat (12) @(negedge clk);
        reg_read(REG_AUTO_RESEED_ENABLES, 8'h05);
        expect_close();
        $display("test stop ignored done");
        pulse(3'h7, 3'h0, 3'h0, 3'h5);
        pulse(3'h0, 3'h7, 3'h0, 3'h5);
        pulse(3'h2, 3'h0, 3'h2, 3'h2);
        reg_write(REG_AUTO_RESEED_ENABLES, 8'hfa);
        reg_read(REG_AUTO_RESEED_ENABLES, 8'h02);
        pulse(3'h7, 3'h7, 3'h0, 3'h2);
        // Frozen core: a request must not reach the command
        ce    = 1'b0;
        other = 3'h7;
        @(negedge clk);
        check({5'h00, reseed_cmd}, 8'h00);
        ce    = 1'b1;
        other = 3'h0;
        @(negedge clk);
        $display("test reseed gating done");
        reg_write(REG_BUS_WINDOW_SETTINGS, 8'h01);
        repeat (10) @(negedge clk);
        check({7'h00, window_open}, 8'h00);
        check({7'h00, stop_disable}, 8'h00);
        $display("test stop restore done");
        tally_and_finish();
    end
endmodule : testbench
